// ===== rtl/dcq_map.svh
// Register map, field positions, reset values and codes of the channel queue block.
// Assumes byte addresses on a 32-bit register bus, one aligned word per register.
`ifndef DCQ_MAP_SVH
`define DCQ_MAP_SVH

`define DCQ_OFF_CAP 12'h004
`define DCQ_OFF_QMAP0 12'h200
`define DCQ_OFF_CHQ0 12'h240
`define DCQ_OFF_QCHQ 12'h260
`define DCQ_OFF_MISS 12'h300
`define DCQ_OFF_MISS_CLR 12'h308
`define DCQ_OFF_QMISS 12'h310
`define DCQ_OFF_QMISS_CLR 12'h314
`define DCQ_OFF_REEVAL 12'h320
`define DCQ_REG_STRIDE 12'h004

`define DCQ_CAP_PROT_BIT 25
`define DCQ_CAP_CHMAP_BIT 24
`define DCQ_CAP_REGN_LSB 20
`define DCQ_CAP_QUEUE_LSB 16
`define DCQ_CAP_PSET_LSB 12
`define DCQ_CAP_IRQ_LSB 8
`define DCQ_CAP_QCH_LSB 4
`define DCQ_CAP_CH_LSB 0
`define DCQ_CAP_PROT_CODE 1'h0
`define DCQ_CAP_CHMAP_CODE 1'h0
`define DCQ_CAP_REGN_CODE 2'h2
`define DCQ_CAP_QUEUE_CODE 3'h1
`define DCQ_CAP_PSET_CODE 3'h3
`define DCQ_CAP_IRQ_CODE 3'h3
`define DCQ_CAP_QCH_CODE 3'h4
`define DCQ_CAP_CH_CODE 3'h4

`define DCQ_QMAP_SET_LSB 5
`define DCQ_QMAP_SET_W 9
`define DCQ_QMAP_WORD_LSB 2
`define DCQ_QMAP_WORD_W 3
`define DCQ_QMAP_SET_RST 9'h000
`define DCQ_QMAP_WORD_RST 3'h0

`define DCQ_QSEL_W 3
`define DCQ_QSEL_STRIDE 4
`define DCQ_QSEL_PER_REG 8
`define DCQ_QSEL_MASK 32'h7777_7777
`define DCQ_QSEL_Q1 3'h1
`define DCQ_QMISS_MASK 32'h0000_00FF
`define DCQ_REEVAL_BIT 0

`define DCQ_RST_ZERO 32'h0000_0000
`define DCQ_RESP_OKAY 2'h0
`define DCQ_RESP_SLVERR 2'h2

`endif

// ===== rtl/dcq_pkg.sv
// Types shared by the channel queue block.
// Assumes the constants of dcq_map.svh.
package dcq_pkg;
   typedef logic [31:0] dcq_word_t;
   typedef logic [3:0] dcq_strb_t;
   typedef logic [8:0] dcq_pset_t;
   typedef logic [2:0] dcq_tword_t;
endpackage

// ===== rtl/dcq_top.sv
// Channel queue, quick channel mapping and missed-event error logic with an AXI4-Lite slave.
// Assumes event, service and null inputs are one-cycle pulses from logic on mclk.
`include "dcq_map.svh"

// Summary of operation
// R1 - Capability word reports no channel mapping; set n belongs to channel n.
// R2 - Capability bits 21-20 read code 2h, four shadow regions.
// R3 - Capability bits 18-16 read code 1h, two event queues.
// R4 - Capability bits 14-12 read code 3h, 128 parameter sets.
// R5 - Capability bits 10-8 read code 3h, 32 completion interrupt channels.
// R6 - Capability bits 6-4 read code 4h, eight quick channels.
// R7 - Capability bits 2-0 read code 4h, 32 channels.
// R8 - Quick maps reset to set 0; software remaps before use.
// R9 - Quick map bits 13-5 hold a writable set index; 80h up reserved.
// R10 - Quick map bits 4-2 pick trigger word; its write is a quick event.
// R11 - 32 three-bit queue fields, eight per register, 4-bit spacing, reset 0.
// R12 - Queue value 0 means queue 0, 1h queue 1; others reserved.
// R13 - Queue 0 feeds controller 0, queue 1 feeds controller 1.
// R14 - Quick queue register holds eight 3-bit queue fields, same coding.
// R15 - Software sets controller priority elsewhere, not in legacy priority word.
// R16 - Second event before service sets missed flag; each source tracked alone.
// R17 - Null entry or null request also sets the channel missed flag.
// R18 - Error pulse when a flag sets while all error flags were clear.
// R19 - Missed flags hold until a 1 is written to the clear word.
// R20 - Quick channels get missed flags for double events or null hits.
// R21 - Writing 1 to re-evaluate pulses the error output if errors remain.
// R22 - Reserved bits read zero; read-only writes are ignored.
module dcq_top #(
   parameter int NCH = 32,
   parameter int NQCH = 8,
   parameter int ADDR_W = 12
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] hw_evt,
   input wire logic [NCH-1:0] hw_svc,
   input wire logic [NCH-1:0] man_evt,
   input wire logic [NCH-1:0] man_svc,
   input wire logic [NCH-1:0] chn_evt,
   input wire logic [NCH-1:0] chn_svc,
   input wire logic [NCH-1:0] null_hit,
   input wire logic pram_wr,
   input wire logic [8:0] pram_wr_set,
   input wire logic [2:0] pram_wr_word,
   input wire logic [NQCH-1:0] quick_svc,
   input wire logic [NQCH-1:0] quick_null_hit,
   input wire logic other_err_any,
   output logic [NCH-1:0] xfer0_req,
   output logic [NCH-1:0] xfer1_req,
   output logic [NQCH-1:0] quick_xfer0_req,
   output logic [NQCH-1:0] quick_xfer1_req,
   output logic err_pulse
);

   localparam int NCHQ = NCH / `DCQ_QSEL_PER_REG;
   localparam int FLAT_W = NCH * `DCQ_QSEL_STRIDE;
   logic aw_hold_q;
   logic w_hold_q;
   logic [ADDR_W-1:0] awaddr_q;
   dcq_pkg::dcq_word_t wdata_q;
   dcq_pkg::dcq_strb_t wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   dcq_pkg::dcq_word_t rdata_q;
   logic wr_fire;
   logic wr_hit;
   logic rd_hit;
   dcq_pkg::dcq_word_t rd_word;
   dcq_pkg::dcq_pset_t qset_q [NQCH];
   dcq_pkg::dcq_tword_t qword_q [NQCH];
   dcq_pkg::dcq_word_t chq_q [NCHQ];
   dcq_pkg::dcq_word_t qchq_q;
   logic [NCH*`DCQ_QSEL_STRIDE-1:0] chq_flat;
   logic [NCH-1:0] hw_pend_q;
   logic [NCH-1:0] man_pend_q;
   logic [NCH-1:0] chn_pend_q;
   logic [NQCH-1:0] quick_pend_q;
   logic [NCH-1:0] hw_miss;
   logic [NCH-1:0] man_miss;
   logic [NCH-1:0] chn_miss;
   logic [NQCH-1:0] quick_trig;
   logic [NQCH-1:0] quick_miss;
   logic [NCH-1:0] ch_go;
   logic [NQCH-1:0] quick_go;
   logic [NCH-1:0] missed_flags_q;
   logic [NQCH-1:0] quick_missed_flags_q;
   logic [NCH-1:0] miss_clr;
   logic [NQCH-1:0] quick_miss_clr;
   logic reeval_wr;
   logic err_any;
   logic err_prev_q;

   // Byte-lane merge of a write into a register, limited to its writable bits
   function automatic dcq_pkg::dcq_word_t wmerge(input dcq_pkg::dcq_word_t old, input dcq_pkg::dcq_word_t data,
                                                 input dcq_pkg::dcq_strb_t strb, input dcq_pkg::dcq_word_t mask);
      dcq_pkg::dcq_word_t be;
      for (int b = 0; b < 4; b++) begin
         be[b*8 +: 8] = {8{strb[b]}};
      end
      return (old & ~be) | (data & be & mask);
   endfunction
   // Queue field of channel idx selects queue 1; reserved codes fall back to queue 0
   function automatic logic sel_q1(input logic [NCH*`DCQ_QSEL_STRIDE-1:0] flat, input int idx);
      return flat[idx*`DCQ_QSEL_STRIDE +: `DCQ_QSEL_W] == `DCQ_QSEL_Q1;
   endfunction
   // Byte address of the idx-th register of a group
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [11:0] base, input int idx);
      return ADDR_W'(base + 12'(idx) * `DCQ_REG_STRIDE);
   endfunction
   // Address decode shared by reads and writes
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      logic hit;
      hit = (a == ADDR_W'(`DCQ_OFF_CAP)) || (a == ADDR_W'(`DCQ_OFF_QCHQ))
         || (a == ADDR_W'(`DCQ_OFF_MISS)) || (a == ADDR_W'(`DCQ_OFF_MISS_CLR))
         || (a == ADDR_W'(`DCQ_OFF_QMISS)) || (a == ADDR_W'(`DCQ_OFF_QMISS_CLR))
         || (a == ADDR_W'(`DCQ_OFF_REEVAL));
      for (int i = 0; i < NQCH; i++) begin
         hit = hit || (a == reg_addr(`DCQ_OFF_QMAP0, i));
      end
      for (int j = 0; j < NCHQ; j++) begin
         hit = hit || (a == reg_addr(`DCQ_OFF_CHQ0, j));
      end
      return hit;
   endfunction
   // AXI4-Lite write side: address and data taken in either order
   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready = !w_hold_q && !bvalid_q;
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign wr_hit = addr_hit(awaddr_q);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         w_hold_q <= 1'b0;
         wdata_q <= `DCQ_RST_ZERO;
         wstrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= `DCQ_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? `DCQ_RESP_OKAY : `DCQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   // Read side: one read under way, answered the cycle after it is taken
   assign s_axi_arready = !rvalid_q;
   assign rd_hit = addr_hit(s_axi_araddr);
   always_comb begin
      rd_word = `DCQ_RST_ZERO;
      if (s_axi_araddr == ADDR_W'(`DCQ_OFF_CAP)) begin
         rd_word[`DCQ_CAP_PROT_BIT] = `DCQ_CAP_PROT_CODE;
         rd_word[`DCQ_CAP_CHMAP_BIT] = `DCQ_CAP_CHMAP_CODE; // R1
         rd_word[`DCQ_CAP_REGN_LSB +: 2] = `DCQ_CAP_REGN_CODE; // R2
         rd_word[`DCQ_CAP_QUEUE_LSB +: 3] = `DCQ_CAP_QUEUE_CODE; // R3
         rd_word[`DCQ_CAP_PSET_LSB +: 3] = `DCQ_CAP_PSET_CODE; // R4
         rd_word[`DCQ_CAP_IRQ_LSB +: 3] = `DCQ_CAP_IRQ_CODE; // R5
         rd_word[`DCQ_CAP_QCH_LSB +: 3] = `DCQ_CAP_QCH_CODE; // R6
         rd_word[`DCQ_CAP_CH_LSB +: 3] = `DCQ_CAP_CH_CODE; // R7
      end
      for (int i = 0; i < NQCH; i++) begin
         if (s_axi_araddr == reg_addr(`DCQ_OFF_QMAP0, i)) begin
            rd_word[`DCQ_QMAP_SET_LSB +: `DCQ_QMAP_SET_W] = qset_q[i];
            rd_word[`DCQ_QMAP_WORD_LSB +: `DCQ_QMAP_WORD_W] = qword_q[i];
         end
      end
      for (int j = 0; j < NCHQ; j++) begin
         if (s_axi_araddr == reg_addr(`DCQ_OFF_CHQ0, j)) begin
            rd_word = chq_q[j];
         end
      end
      if (s_axi_araddr == ADDR_W'(`DCQ_OFF_QCHQ)) begin
         rd_word = qchq_q;
      end
      if (s_axi_araddr == ADDR_W'(`DCQ_OFF_MISS)) begin
         rd_word = 32'(missed_flags_q);
      end
      if (s_axi_araddr == ADDR_W'(`DCQ_OFF_QMISS)) begin
         rd_word = 32'(quick_missed_flags_q);
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rvalid_q <= 1'b0;
         rresp_q <= `DCQ_RESP_OKAY;
         rdata_q <= `DCQ_RST_ZERO;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_hit ? `DCQ_RESP_OKAY : `DCQ_RESP_SLVERR;
         rdata_q <= rd_word; // R22
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   // Quick channel maps: set index and trigger word
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NQCH; i++) begin
            qset_q[i] <= `DCQ_QMAP_SET_RST; // R8
            qword_q[i] <= `DCQ_QMAP_WORD_RST;
         end
      end else if (wr_fire) begin
         for (int i = 0; i < NQCH; i++) begin
            if (awaddr_q == reg_addr(`DCQ_OFF_QMAP0, i)) begin
               qset_q[i] <= dcq_pkg::dcq_pset_t'(wmerge({23'h0, qset_q[i]} << `DCQ_QMAP_SET_LSB, wdata_q, wstrb_q,
                                   32'h0000_3FE0) >> `DCQ_QMAP_SET_LSB); // R9
               qword_q[i] <= dcq_pkg::dcq_tword_t'(wmerge({29'h0, qword_q[i]} << `DCQ_QMAP_WORD_LSB, wdata_q, wstrb_q,
                                    32'h0000_001C) >> `DCQ_QMAP_WORD_LSB); // R10
            end
         end
      end
   end

   // Channel and quick channel queue selects
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int j = 0; j < NCHQ; j++) begin
            chq_q[j] <= `DCQ_RST_ZERO; // R11
         end
      end else if (wr_fire) begin
         for (int j = 0; j < NCHQ; j++) begin
            if (awaddr_q == reg_addr(`DCQ_OFF_CHQ0, j)) begin
               chq_q[j] <= wmerge(chq_q[j], wdata_q, wstrb_q, `DCQ_QSEL_MASK); // R11
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         qchq_q <= `DCQ_RST_ZERO;
      end else if (wr_fire && awaddr_q == ADDR_W'(`DCQ_OFF_QCHQ)) begin
         qchq_q <= wmerge(qchq_q, wdata_q, wstrb_q, `DCQ_QSEL_MASK); // R14
      end
   end
   always_comb begin
      for (int j = 0; j < NCHQ; j++) begin
         chq_flat[j*32 +: 32] = chq_q[j];
      end
   end

   // Write-only clear and re-evaluate strobes
   always_comb begin
      miss_clr = '0;
      quick_miss_clr = '0;
      reeval_wr = 1'b0;
      if (wr_fire && awaddr_q == ADDR_W'(`DCQ_OFF_MISS_CLR)) begin
         miss_clr = NCH'(wmerge(`DCQ_RST_ZERO, wdata_q, wstrb_q, {32{1'b1}})); // R19
      end
      if (wr_fire && awaddr_q == ADDR_W'(`DCQ_OFF_QMISS_CLR)) begin
         quick_miss_clr = NQCH'(wmerge(`DCQ_RST_ZERO, wdata_q, wstrb_q, `DCQ_QMISS_MASK)); // R19
      end
      if (wr_fire && awaddr_q == ADDR_W'(`DCQ_OFF_REEVAL) && wstrb_q[0]) begin
         reeval_wr = wdata_q[`DCQ_REEVAL_BIT]; // R21
      end
   end

   // Quick event detection on a write to the mapped trigger word
   always_comb begin
      for (int i = 0; i < NQCH; i++) begin
         quick_trig[i] = pram_wr && pram_wr_set == qset_q[i] && pram_wr_word == qword_q[i]; // R10
      end
   end

   // Pending events per source; a second arrival before service is a miss
   assign hw_miss = hw_evt & hw_pend_q & ~hw_svc; // R16
   assign man_miss = man_evt & man_pend_q & ~man_svc; // R16
   assign chn_miss = chn_evt & chn_pend_q & ~chn_svc; // R16
   assign quick_miss = quick_trig & quick_pend_q & ~quick_svc; // R20
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hw_pend_q <= '0;
         man_pend_q <= '0;
         chn_pend_q <= '0;
      end else begin
         hw_pend_q <= (hw_pend_q & ~hw_svc) | hw_evt;
         man_pend_q <= (man_pend_q & ~man_svc) | man_evt;
         chn_pend_q <= (chn_pend_q & ~chn_svc) | chn_evt;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         quick_pend_q <= '0;
      end else begin
         quick_pend_q <= (quick_pend_q & ~quick_svc) | quick_trig;
      end
   end

   // Missed flags: a new set wins over a clear in the same cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         missed_flags_q <= '0;
      end else begin
         missed_flags_q <= (missed_flags_q & ~miss_clr) | hw_miss | man_miss | chn_miss | null_hit; // R16 R17 R19
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         quick_missed_flags_q <= '0;
      end else begin
         quick_missed_flags_q <= (quick_missed_flags_q & ~quick_miss_clr) | quick_miss | quick_null_hit; // R20
      end
   end

   // Accepted events go to the controller of their queue
   assign ch_go = (hw_evt & ~hw_miss) | (man_evt & ~man_miss) | (chn_evt & ~chn_miss);
   assign quick_go = quick_trig & ~quick_miss;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         xfer0_req <= '0;
         xfer1_req <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            xfer0_req[c] <= ch_go[c] && !sel_q1(chq_flat, c); // R12 R13
            xfer1_req[c] <= ch_go[c] && sel_q1(chq_flat, c); // R12 R13
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         quick_xfer0_req <= '0;
         quick_xfer1_req <= '0;
      end else begin
         for (int k = 0; k < NQCH; k++) begin
            quick_xfer0_req[k] <= quick_go[k] && !sel_q1(FLAT_W'(qchq_q), k); // R13 R14
            quick_xfer1_req[k] <= quick_go[k] && sel_q1(FLAT_W'(qchq_q), k); // R13 R14
         end
      end
   end

   // Error pulse on the edge from no error to some error, or on re-evaluate while errors remain
   assign err_any = (|missed_flags_q) || (|quick_missed_flags_q) || other_err_any;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         err_prev_q <= 1'b0;
         err_pulse <= 1'b0;
      end else begin
         err_prev_q <= err_any;
         err_pulse <= (err_any && !err_prev_q) || (reeval_wr && err_any); // R18 R21
      end
   end
endmodule // dcq_top

// ===== testbench/dcq_top_props.sv
// Concurrent checks on the register bus and request outputs of the channel queue block.
// Assumes it is bound into dcq_top and sees only that module's ports.
module dcq_top_props #(
   parameter int NCH = 32,
   parameter int NQCH = 8,
   parameter int ADDR_W = 12
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic [NCH-1:0] hw_evt,
   input wire logic [NCH-1:0] man_evt,
   input wire logic [NCH-1:0] chn_evt,
   input wire logic [NCH-1:0] xfer0_req,
   input wire logic [NCH-1:0] xfer1_req,
   input wire logic [NQCH-1:0] quick_xfer0_req,
   input wire logic [NQCH-1:0] quick_xfer1_req,
   input wire logic err_pulse
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   a_cap_word_value: assert property (s_ar_take ##0 s_axi_araddr == 12'h004 |=> s_axi_rdata == 32'h0021_3344)
      else $error("capability word read wrong");
   a_clr_reads_zero: assert property (s_ar_take ##0 s_axi_araddr == 12'h308 |=> s_axi_rdata == 32'h0000_0000)
      else $error("clear word read not zero");
   a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
   a_one_controller: assert property ((xfer0_req & xfer1_req) == '0)
      else $error("request sent to both controllers");
   a_quick_one_ctrl: assert property ((quick_xfer0_req & quick_xfer1_req) == '0)
      else $error("quick request sent to both controllers");
   a_req_has_cause: assert property (|(xfer0_req | xfer1_req) |->
      ((xfer0_req | xfer1_req) & ~($past(hw_evt) | $past(man_evt) | $past(chn_evt))) == '0)
      else $error("request without event");
   a_err_is_pulse: assert property (err_pulse |=> !err_pulse)
      else $error("error output longer than one cycle");
endmodule // dcq_top_props

bind dcq_top dcq_top_props #(.NCH(NCH), .NQCH(NQCH), .ADDR_W(ADDR_W)) u_props (.*);

// ===== testbench/dcq_xfer_sink.sv
// Model of the two transfer controllers and the error interrupt sink.
// Assumes request and error outputs are one-cycle pulses on mclk.
module dcq_xfer_sink (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [31:0] req0,
   input wire logic [31:0] req1,
   input wire logic [7:0] qreq0,
   input wire logic [7:0] qreq1,
   input wire logic err_pulse,
   output logic [31:0] got0,
   output logic [31:0] got1,
   output logic [7:0] qgot0,
   output logic [7:0] qgot1,
   output int errs
);
   timeunit 1ns;
   timeprecision 1ps;
   // Each controller records only what arrives on its own queue
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         got0 <= '0;
         got1 <= '0;
         qgot0 <= '0;
         qgot1 <= '0;
         errs <= 0;
      end else begin
         got0 <= got0 | req0;
         got1 <= got1 | req1;
         qgot0 <= qgot0 | qreq0;
         qgot1 <= qgot1 | qreq1;
         errs <= errs + int'(err_pulse === 1'b1);
      end
   end
endmodule // dcq_xfer_sink

// ===== testbench/test_dma_channel_queue_error_regs.sv
// Self-checking bench for the channel queue block over AXI4-Lite.
// Assumes dcq_top with its checker bound and the controller sink model.
module test_dma_channel_queue_error_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, pram_wr_word = 3'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, pram_wr = 1'b0, other_err_any = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000, src [9];
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [8:0] pram_wr_set = 9'h000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, err_pulse;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [31:0] s_axi_rdata, xfer0_req, xfer1_req, got0, got1, d;
   logic [7:0] quick_xfer0_req, quick_xfer1_req, qgot0, qgot1;
   int num_errors = 0, compares = 0, cycles = 0, errs, e0;

   dcq_top u_dut (.hw_evt(src[0]), .hw_svc(src[1]), .man_evt(src[2]), .man_svc(src[3]),
      .chn_evt(src[4]), .chn_svc(src[5]), .null_hit(src[6]), .quick_svc(src[7][7:0]),
      .quick_null_hit(src[8][7:0]), .*);
   dcq_xfer_sink u_sink (.mclk(mclk), .resetn(resetn), .req0(xfer0_req), .req1(xfer1_req),
      .qreq0(quick_xfer0_req), .qreq1(quick_xfer1_req), .err_pulse(err_pulse),
      .got0(got0), .got1(got1), .qgot0(qgot0), .qgot1(qgot1), .errs(errs));

   always #10 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end

   task automatic conclude();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask

   // Handshakes are judged from values settled before the edge that takes them
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw_t, w_t, b_t;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_t = 1'b0;
      while (b_t !== 1'b1) begin
         @(negedge mclk);
         aw_t = s_axi_awvalid && s_axi_awready;
         w_t = s_axi_wvalid && s_axi_wready;
         b_t = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge mclk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic chk(input logic [11:0] a, input logic [31:0] e, input string n);
      logic ar_t, r_t;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_t = 1'b0;
      while (r_t !== 1'b1) begin
         @(negedge mclk);
         ar_t = s_axi_arvalid && s_axi_arready;
         r_t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge mclk);
         if (ar_t) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      cmp(n, e, d);
   endtask

   task automatic pulse(input int s, input logic [31:0] m);
      @(posedge mclk);
      src[s] <= m;
      @(posedge mclk);
      src[s] <= 32'h0000_0000;
      repeat (3) @(posedge mclk);
   endtask

   task automatic qev(input logic [2:0] w);
      @(posedge mclk);
      pram_wr <= 1'b1;
      pram_wr_set <= 9'h005;
      pram_wr_word <= w;
      @(posedge mclk);
      pram_wr <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask

   task automatic t_reset();
      chk(12'h004, 32'h0021_3344, "capability");
      for (int i = 0; i < 8; i++) chk(12'h200 + 12'(4 * i), 32'h0, "quick map reset");
      for (int i = 0; i < 4; i++) chk(12'h240 + 12'(4 * i), 32'h0, "queue select reset");
      chk(12'h260, 32'h0, "quick queue reset");
      chk(12'h300, 32'h0, "missed reset");
   endtask

   task automatic t_regs();
      wr(12'h20C, 32'hFFFF_FFFF);
      cmp("write resp", 32'h0, {30'h0, r});
      chk(12'h20C, 32'h0000_3FFC, "quick map fields");
      cmp("read resp", 32'h0, {30'h0, r});
      wr(12'h244, 32'hFFFF_FFFF);
      chk(12'h244, 32'h7777_7777, "queue select fields");
      wr(12'h260, 32'hFFFF_FFFF);
      chk(12'h260, 32'h7777_7777, "quick queue fields");
      wr(12'h004, 32'hFFFF_FFFF);
      chk(12'h004, 32'h0021_3344, "capability kept");
      wr(12'h284, 32'h0000_0001);
      cmp("unmapped resp", 32'h2, {30'h0, r});
      chk(12'h284, 32'h0, "unmapped read");
      cmp("unmapped rresp", 32'h2, {30'h0, r});
   endtask

   task automatic t_route();
      wr(12'h240, 32'h0000_0210);
      pulse(0, 32'h0000_0007);
      pulse(2, 32'h0000_0008);
      cmp("controller 0", 32'h0000_000D, got0);
      cmp("controller 1", 32'h0000_0002, got1);
      pulse(1, 32'h0000_0007);
      pulse(3, 32'h0000_0008);
   endtask

   task automatic t_missed();
      e0 = errs;
      pulse(0, 32'h0000_0050);
      pulse(0, 32'h0000_0010);
      pulse(4, 32'h0000_0040);
      chk(12'h300, 32'h0000_0010, "missed per source");
      cmp("first error", 32'(e0 + 1), 32'(errs));
      pulse(6, 32'h0000_0020);
      chk(12'h300, 32'h0000_0030, "missed null");
      cmp("no second error", 32'(e0 + 1), 32'(errs));
      wr(12'h308, 32'h0000_0000);
      chk(12'h308, 32'h0, "clear reads zero");
      chk(12'h300, 32'h0000_0030, "clear zero");
      wr(12'h308, 32'h0000_0010);
      chk(12'h300, 32'h0000_0020, "clear one");
      wr(12'h320, 32'h0000_0001);
      chk(12'h300, 32'h0000_0020, "flags after error_reevaluate_bit");
      cmp("error_reevaluate_bit error", 32'(e0 + 2), 32'(errs));
      wr(12'h308, 32'h0000_0020);
      wr(12'h320, 32'h0000_0001);
      chk(12'h300, 32'h0, "all cleared");
      cmp("error_reevaluate_bit idle", 32'(e0 + 2), 32'(errs));
      other_err_any <= 1'b1;
      pulse(6, 32'h0000_0080);
      chk(12'h300, 32'h0000_0080, "flag under outside error");
      cmp("outside error", 32'(e0 + 3), 32'(errs));
      other_err_any <= 1'b0;
      wr(12'h308, 32'h0000_0080);
      pulse(1, 32'h0000_0050);
      pulse(5, 32'h0000_0040);
   endtask

   task automatic t_quick();
      wr(12'h208, 32'h0000_00AC);
      wr(12'h260, 32'h0000_0100);
      qev(3'h2);
      cmp("wrong word", 32'h0, {24'h0, qgot0 | qgot1});
      qev(3'h3);
      qev(3'h3);
      cmp("quick controller 1", 32'h4, {24'h0, qgot1});
      cmp("quick controller 0", 32'h0, {24'h0, qgot0});
      chk(12'h310, 32'h0000_0004, "quick missed");
      pulse(8, 32'h0000_0040);
      chk(12'h310, 32'h0000_0044, "quick null");
      wr(12'h314, 32'h0000_0044);
      chk(12'h310, 32'h0, "quick cleared");
      pulse(7, 32'h0000_0004);
   endtask

   initial begin
      foreach (src[i]) src[i] = 32'h0000_0000;
      repeat (6) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_regs();
      t_route();
      t_missed();
      t_quick();
      conclude();
   end
endmodule // test_dma_channel_queue_error_regs
